// [hw/wss_consts.svh]
// constants for the wlan strap sampler: offsets, fields, reset values, timing
// Functional notes
// - sample every strap pin once, 1 ms after internal or external reset release
// - after sampling, hand each strap pin back to its normal function
// - internal pull toward default level so an undriven strap decodes as default
// - pins 7:6 select config source: otp, serial rom or defaults
// - undriven config-source strap behaves as value 01
// - pin 8 low holds host interface and processor in reset
// - pins 10:9 select boot: sram held, rom, flash, or invalid
// - pin 13 high selects internal 32 kHz oscillator, else external clock
// - power-up strap 00 gives lowest power mode, slow oscillator only
// - power-up 01 idle clock request, 10 crystal, 11 pll running
// - after sampling, pins 0 to 2 may carry wake and standby sideband
`ifndef WSS_CONSTS_SVH
`define WSS_CONSTS_SVH
`define WSS_REG_STATUS 12'h000
`define WSS_REG_DECODE 12'h004
`define WSS_REG_SB_CTRL 12'h008
`define WSS_SB_EN_BIT 0
`define WSS_SB_WAKE_BIT 1
`define WSS_SB_STBY_BIT 2
`define WSS_SB_DEVWAKE_BIT 8
`define WSS_STATUS_DONE_BIT 16
`define WSS_SB_CTRL_RST 3'h0
// strap pins actually sampled, and the level each one is pulled toward
`define WSS_STRAP_MASK 16'hEFC0
`define WSS_STRAP_DEFAULT 16'h8140
`define WSS_SIDEBAND_MASK 16'h0007
`define WSS_SETTLE_US 1000
`define WSS_CLK_MHZ 25
`endif

// [hw/wss_pkg.sv]
// types of the wlan strap sampler
package wss_pkg;
  typedef enum logic [1:0] {WSS_WAIT_EXT, WSS_SETTLE, WSS_DONE} wss_state_t;
  typedef enum logic [1:0] {WSS_CIS_DEFAULT, WSS_CIS_SERIAL_CONFIG_ROM, WSS_CIS_OTP} wss_cis_t;
  typedef enum logic [1:0] {WSS_BOOT_SRAM, WSS_BOOT_ROM, WSS_BOOT_FLASH, WSS_BOOT_BAD} wss_boot_t;
  typedef enum logic [1:0] {WSS_PWR_LOWEST, WSS_PWR_IDLE_CLK, WSS_PWR_XTAL, WSS_PWR_PLL} wss_pwr_t;
  typedef struct packed {
    logic otp_powered;
    logic id_from_otp;
    wss_cis_t cis_src;
    logic host_if_in_reset;
    logic cpu_in_reset;
    wss_boot_t boot_src;
    logic boot_invalid;
    logic lp_clk_internal;
    wss_pwr_t pwrup_mode;
    logic debug_strap_high;
  } wss_cfg_t;
  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe;
    logic [15:0] pull_en;
    logic [15:0] pull_up;
  } wss_pins_t;
endpackage : wss_pkg

// [hw/wss_strap_sampler.sv]
// strap capture, decode, pin hand-back and apb status for the wlan section
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`include "wss_consts.svh"
module wss_strap_sampler #(
  parameter int SETTLE_CYCLES = `WSS_SETTLE_US * `WSS_CLK_MHZ
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_por_n,
  input wire logic [15:0] gp_pin_in,
  output logic [15:0] gp_pin_out,
  output logic [15:0] gp_pin_oe,
  output logic [15:0] gp_pull_en,
  output logic [15:0] gp_pull_up,
  input wire logic [15:0] gpio_core_out,
  input wire logic [15:0] gpio_core_oe,
  output logic [15:0] gpio_core_in,
  output wss_pkg::wss_cfg_t strap_cfg,
  output logic strap_done,
  output logic device_wake_in
);
  localparam int CW = $clog2(SETTLE_CYCLES + 1);

  // turn raw strap levels into settings
  function automatic wss_pkg::wss_cfg_t decode(input logic [15:0] s);
    wss_pkg::wss_cfg_t c;
    c = '0;
    c.otp_powered = ~(s[7] & s[6]);
    c.id_from_otp = ~(s[7] & s[6]);
    case (s[7:6])
      2'h0: c.cis_src = wss_pkg::WSS_CIS_DEFAULT;
      2'h2: c.cis_src = wss_pkg::WSS_CIS_OTP;
      default: c.cis_src = wss_pkg::WSS_CIS_SERIAL_CONFIG_ROM;
    endcase
    c.boot_src = wss_pkg::wss_boot_t'(s[10:9]);
    c.boot_invalid = (s[10:9] == 2'h3);
    c.host_if_in_reset = ~s[8];
    // processor only runs when host side is up and boot picks rom or flash
    c.cpu_in_reset = ~s[8] | (s[10] == s[9]);
    c.lp_clk_internal = s[13];
    c.pwrup_mode = wss_pkg::wss_pwr_t'(s[15:14]);
    c.debug_strap_high = s[11];
    return c;
  endfunction : decode

  // two-flop synchronisers for every pin input
  logic [15:0] pin_meta_ff, pin_sync_ff;
  logic por_meta_ff, por_sync_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_ff <= 16'h0000;
      pin_sync_ff <= 16'h0000;
      por_meta_ff <= 1'b0;
      por_sync_ff <= 1'b0;
    end else begin
      pin_meta_ff <= gp_pin_in;
      pin_sync_ff <= pin_meta_ff;
      por_meta_ff <= ext_por_n;
      por_sync_ff <= por_meta_ff;
    end
  end

  // capture sequencer: wait external reset, let pulls settle, then sample once
  wss_pkg::wss_state_t state_ff, nxt_state;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic [15:0] raw_ff, nxt_raw;
  wss_pkg::wss_cfg_t cfg_ff, nxt_cfg;
  logic done_ff, nxt_done;
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_raw = raw_ff;
    nxt_cfg = cfg_ff;
    case (state_ff)
      wss_pkg::WSS_WAIT_EXT: begin
        nxt_cnt = '0;
        if (por_sync_ff) begin
          nxt_state = wss_pkg::WSS_SETTLE;
        end
      end
      wss_pkg::WSS_SETTLE: begin
        if (!por_sync_ff) begin
          nxt_state = wss_pkg::WSS_WAIT_EXT; // external reset again restarts the wait
        end else if (cnt_ff == CW'(SETTLE_CYCLES - 1)) begin
          nxt_raw = pin_sync_ff & `WSS_STRAP_MASK;
          nxt_cfg = decode(pin_sync_ff);
          nxt_state = wss_pkg::WSS_DONE;
        end else begin
          nxt_cnt = cnt_ff + CW'(1);
        end
      end
      wss_pkg::WSS_DONE: begin
        nxt_state = wss_pkg::WSS_DONE;
      end
      default: nxt_state = wss_pkg::WSS_WAIT_EXT;
    endcase
    // done kept in its own flop so strap_done leaves a register, not a compare
    nxt_done = (nxt_state == wss_pkg::WSS_DONE);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= wss_pkg::WSS_WAIT_EXT;
      cnt_ff <= '0;
      raw_ff <= 16'h0000;
      cfg_ff <= '0;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      raw_ff <= nxt_raw;
      cfg_ff <= nxt_cfg;
      done_ff <= nxt_done;
    end
  end
  wire done_w = done_ff;

  // apb slave: one wait state, so read data and pready both come from flops
  logic [2:0] sb_ctrl_ff, nxt_sb_ctrl;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic [31:0] prdata_ff, nxt_prdata;
  logic hit;
  always_comb begin
    nxt_sb_ctrl = sb_ctrl_ff;
    nxt_pready = 1'b0;
    nxt_pslverr = 1'b0;
    nxt_prdata = 32'h0000_0000;
    hit = 1'b0;
    if (psel && penable && !pready_ff) begin
      nxt_pready = 1'b1;
      case (paddr)
        `WSS_REG_STATUS: begin
          hit = 1'b1;
          nxt_prdata = {15'h0000, done_w, raw_ff};
        end
        `WSS_REG_DECODE: begin
          hit = 1'b1;
          nxt_prdata = {19'h00000, cfg_ff};
        end
        `WSS_REG_SB_CTRL: begin
          hit = 1'b1;
          nxt_prdata = {23'h000000, pin_sync_ff[0], 5'h00, sb_ctrl_ff};
          if (pwrite && pstrb[0]) begin
            nxt_sb_ctrl = pwdata[2:0];
          end
        end
        default: hit = 1'b0;
      endcase
      nxt_pslverr = !hit; // unmapped address: error, reads zero
      if (pwrite || !hit) begin
        nxt_prdata = 32'h0000_0000;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sb_ctrl_ff <= `WSS_SB_CTRL_RST;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      sb_ctrl_ff <= nxt_sb_ctrl;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
    end
  end

  // pad control: pulls and no drive while sampling, normal function afterwards
  wss_pkg::wss_pins_t pins_ff, nxt_pins;
  logic [15:0] gpio_in_ff;
  logic dev_wake_ff;
  always_comb begin
    nxt_pins.out = 16'h0000;
    nxt_pins.oe = 16'h0000;
    nxt_pins.pull_en = `WSS_STRAP_MASK;
    nxt_pins.pull_up = `WSS_STRAP_DEFAULT;
    if (done_w) begin
      nxt_pins.out = gpio_core_out;
      nxt_pins.oe = gpio_core_oe;
      nxt_pins.pull_en = 16'h0000;
      nxt_pins.pull_up = 16'h0000;
      if (sb_ctrl_ff[`WSS_SB_EN_BIT]) begin
        // pin 0 listens for device wake, pins 1 and 2 drive host wake and standby
        nxt_pins.oe = (gpio_core_oe & ~`WSS_SIDEBAND_MASK) | 16'h0006;
        nxt_pins.out[2:0] = {sb_ctrl_ff[`WSS_SB_STBY_BIT],
                             sb_ctrl_ff[`WSS_SB_WAKE_BIT], 1'b0};
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_ff <= {16'h0000, 16'h0000, `WSS_STRAP_MASK, `WSS_STRAP_DEFAULT};
      gpio_in_ff <= 16'h0000;
      dev_wake_ff <= 1'b0;
    end else begin
      pins_ff <= nxt_pins;
      gpio_in_ff <= done_w ? pin_sync_ff : 16'h0000;
      dev_wake_ff <= done_w & sb_ctrl_ff[`WSS_SB_EN_BIT] & pin_sync_ff[0];
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign gp_pin_out = pins_ff.out;
  assign gp_pin_oe = pins_ff.oe;
  assign gp_pull_en = pins_ff.pull_en;
  assign gp_pull_up = pins_ff.pull_up;
  assign gpio_core_in = gpio_in_ff;
  assign strap_cfg = cfg_ff;
  assign strap_done = done_w;
  assign device_wake_in = dev_wake_ff;

  // checks
  property p_sample_time;
    @(posedge pclk) disable iff (!presetn)
    $rose(done_w) |-> $past(cnt_ff) == CW'(SETTLE_CYCLES - 1);
  endproperty
  a_sample_time: assert property (p_sample_time) else $error("sampled early");
  property p_no_drive_before;
    @(posedge pclk) disable iff (!presetn)
    !$past(done_w) |-> (gp_pin_oe == 16'h0000);
  endproperty
  a_no_drive_before: assert property (p_no_drive_before) else $error("pin driven");
  property p_handback;
    @(posedge pclk) disable iff (!presetn)
    ($past(done_w) && !$past(sb_ctrl_ff[0])) |-> gp_pin_oe == $past(gpio_core_oe);
  endproperty
  a_handback: assert property (p_handback) else $error("pin not handed back");
  property p_pulls;
    @(posedge pclk) disable iff (!presetn)
    !$past(done_w) |-> gp_pull_en == `WSS_STRAP_MASK && gp_pull_up == `WSS_STRAP_DEFAULT;
  endproperty
  a_pulls: assert property (p_pulls) else $error("strap pull wrong");
  property p_cfg_src;
    @(posedge pclk) disable iff (!presetn)
    $rose(done_w) |-> strap_cfg.otp_powered == !(raw_ff[7] && raw_ff[6]) &&
      (raw_ff[7:6] != 2'h1 || strap_cfg.cis_src == wss_pkg::WSS_CIS_SERIAL_CONFIG_ROM);
  endproperty
  a_cfg_src: assert property (p_cfg_src) else $error("config source decode");
  property p_host_if;
    @(posedge pclk) disable iff (!presetn)
    done_w && !raw_ff[8] |-> strap_cfg.host_if_in_reset && strap_cfg.cpu_in_reset;
  endproperty
  a_host_if: assert property (p_host_if) else $error("host reset decode");
  property p_boot;
    @(posedge pclk) disable iff (!presetn)
    done_w |-> strap_cfg.boot_invalid == (raw_ff[10:9] == 2'h3) &&
      strap_cfg.boot_src == wss_pkg::wss_boot_t'(raw_ff[10:9]);
  endproperty
  a_boot: assert property (p_boot) else $error("boot decode");
  property p_clk_pwr;
    @(posedge pclk) disable iff (!presetn)
    done_w |-> strap_cfg.lp_clk_internal == raw_ff[13] &&
      strap_cfg.pwrup_mode == wss_pkg::wss_pwr_t'(raw_ff[15:14]);
  endproperty
  a_clk_pwr: assert property (p_clk_pwr) else $error("clock or power decode");
  property p_sideband;
    @(posedge pclk) disable iff (!presetn)
    $past(done_w) && $past(sb_ctrl_ff[0]) |->
      gp_pin_oe[2:0] == 3'h6 && gp_pin_out[1] == $past(sb_ctrl_ff[1]);
  endproperty
  a_sideband: assert property (p_sideband) else $error("sideband pins");
  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    $past(done_w) |-> $stable(strap_cfg) && $stable(raw_ff) && done_w;
  endproperty
  a_hold: assert property (p_hold) else $error("straps changed");
  // the gpio core sees nothing of the pins until the straps are taken
  property p_core_in_quiet;
    @(posedge pclk) disable iff (!presetn)
    !$past(done_w) |-> gpio_core_in == 16'h0000;
  endproperty
  a_core_in_quiet: assert property (p_core_in_quiet) else $error("core input early");
  property p_pulls_off;
    @(posedge pclk) disable iff (!presetn)
    $past(done_w) |-> gp_pull_en == 16'h0000 && gp_pull_up == 16'h0000;
  endproperty
  a_pulls_off: assert property (p_pulls_off) else $error("pulls left on");
  // processor runs only with host side up and a rom or flash boot
  property p_cpu_run;
    @(posedge pclk) disable iff (!presetn)
    done_w && raw_ff[8] |-> strap_cfg.cpu_in_reset == (raw_ff[10] == raw_ff[9]);
  endproperty
  a_cpu_run: assert property (p_cpu_run) else $error("processor reset decode");
  // no capture while the external reset pin still holds the block
  property p_wait_ext;
    @(posedge pclk) disable iff (!presetn)
    !por_sync_ff && !done_w |=> !done_w;
  endproperty
  a_wait_ext: assert property (p_wait_ext) else $error("sampled during reset");
  property p_dev_wake;
    @(posedge pclk) disable iff (!presetn)
    $past(done_w) && $past(sb_ctrl_ff[0]) |-> device_wake_in == $past(pin_sync_ff[0]);
  endproperty
  a_dev_wake: assert property (p_dev_wake) else $error("device wake path");
  // ready is a single-cycle answer and an error only rides on it
  property p_ready_pulse;
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
  property p_err_with_ready;
    @(posedge pclk) disable iff (!presetn)
    pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
endmodule : wss_strap_sampler

// [verification/wss_board.sv]
// board side of the strap pins: external resistors and pad level resolution
`timescale 1ns/1ns
module wss_board (
  input wire logic pclk,
  input wire logic [15:0] brd_en,
  input wire logic [15:0] brd_val,
  input wire logic [15:0] dev_out,
  input wire logic [15:0] dev_oe,
  input wire logic [15:0] pull_en,
  input wire logic [15:0] pull_up,
  output logic [15:0] pad
);
  logic tgl_ff = 1'b0;
  logic [15:0] val;
  // the board never pulls the debug strap high
  assign val = brd_val & 16'hF7FF;
  // a floating pin toggles so a stale level never passes for a driven one
  always @(posedge pclk) tgl_ff <= ~tgl_ff;
  // device drive wins, then board resistor, then internal pull, else floating
  assign pad = (dev_oe & dev_out) | (~dev_oe & brd_en & val)
    | (~dev_oe & ~brd_en & pull_en & pull_up) | (~dev_oe & ~brd_en & ~pull_en & {16{tgl_ff}});
endmodule : wss_board

// [verification/wss_strap_sampler_tb.sv]
// self-checking bench for the strap sampler with random board straps
`timescale 1ns/1ns
`define CHK(nm, e, s) begin comparisons++; if ((e) !== (s)) begin failures++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, s); end end
module wlan_strap_sampler_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, ext_n = 1'b1, strap_done, device_wake_in, er;
  logic [15:0] pad, gp_out, gp_oe, pull_en, pull_up, core_in, en = 16'h0, val = 16'h0;
  logic [15:0] core_out = 16'h0, core_oe = 16'h0, eff;
  wss_pkg::wss_cfg_t strap_cfg, exp;
  integer failures = 0, comparisons = 0, seed = 32'h131B, cyc = 0, n;
  // one drive per pin: device pads, board resistors and internal pulls
  wss_board wss_board_inst (.pclk(pclk), .brd_en(en), .brd_val(val), .dev_out(gp_out),
    .dev_oe(gp_oe), .pull_en(pull_en), .pull_up(pull_up), .pad(pad));
  wss_strap_sampler #(.SETTLE_CYCLES(8)) wss_strap_sampler_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_por_n(ext_n), .gp_pin_in(pad), .gp_pin_out(gp_out), .gp_pin_oe(gp_oe),
    .gp_pull_en(pull_en), .gp_pull_up(pull_up), .gpio_core_out(core_out),
    .gpio_core_oe(core_oe), .gpio_core_in(core_in), .strap_cfg(strap_cfg),
    .strap_done(strap_done), .device_wake_in(device_wake_in));
  always #20 pclk = ~pclk;
  // a hang is cut short well above the expected run length
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      failures++;
      test_done();
    end
  end
  // decode of the straps as the pins should have resolved them
  function automatic wss_pkg::wss_cfg_t exp_cfg(input logic [15:0] p);
    wss_pkg::wss_cfg_t c;
    c = '0;
    c.otp_powered = (p[7:6] != 2'h3);
    c.id_from_otp = (p[7:6] != 2'h3);
    c.cis_src = (p[7:6] == 2'h0) ? wss_pkg::WSS_CIS_DEFAULT :
      (p[7:6] == 2'h2) ? wss_pkg::WSS_CIS_OTP : wss_pkg::WSS_CIS_SERIAL_CONFIG_ROM;
    c.host_if_in_reset = ~p[8];
    c.boot_src = wss_pkg::wss_boot_t'(p[10:9]);
    c.boot_invalid = (p[10:9] == 2'h3);
    c.cpu_in_reset = ~p[8] | (p[10] == p[9]);
    c.lp_clk_internal = p[13];
    c.pwrup_mode = wss_pkg::wss_pwr_t'(p[15:14]);
    c.debug_strap_high = p[11];
    return c;
  endfunction : exp_cfg
  // one apb transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // pready is judged at rising edges only; a hang is ended by the bench timeout
    do begin @(posedge pclk); end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic test_done();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  initial begin
    for (int i = 0; i < 10; i++) begin
      @(posedge pclk);
      // first four runs force every code, run four leaves every strap floating
      en <= (i < 4) ? 16'hFFFF : (i == 4) ? 16'h0 : 16'($random(seed));
      val <= (i < 4) ? {i[1:0], i[0], 2'h0, i[1:0], i[1], i[1:0], 6'h0} : 16'($random(seed));
      ext_n <= ~i[0];
      core_out <= 16'($random(seed));
      core_oe <= 16'($random(seed));
      presetn <= 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      if (i[0]) begin
        repeat (12) @(posedge pclk);
        `CHK("done while ext low", 1'h0, strap_done)
        ext_n <= 1'b1;
      end
      @(negedge pclk);
      eff = (en & val & 16'hF7FF) | (~en & 16'h8140);
      `CHK("pulls before done", 16'hEFC0, pull_en)
      `CHK("oe before done", 16'h0, gp_oe)
      `CHK("pull dir before done", 16'h8140, pull_up)
      `CHK("core in before done", 16'h0, core_in)
      n = 0;
      while (strap_done !== 1'b1 && n < 40) begin @(negedge pclk); n++; end
      `CHK("done latency", 1'h1, n >= 6 && n <= 14)
      exp = exp_cfg(eff);
      `CHK("strap_cfg", exp, strap_cfg)
      apb(1'b0, 12'h000, 32'h0, 4'hF);
      `CHK("status", {15'h0, 1'h1, eff & 16'hEFC0}, rd)
      `CHK("status error", 1'h0, er)
      apb(1'b0, 12'h004, 32'h0, 4'hF);
      `CHK("decode", {19'h0, exp}, rd)
      apb(1'b0, 12'hFFC, 32'h0, 4'hF);
      `CHK("unmapped error", 1'h1, er)
      `CHK("pulls after done", 16'h0, pull_en)
      `CHK("pull dir after done", 16'h0, pull_up)
      `CHK("pin out after done", core_out, gp_out)
      @(posedge pclk);
      val <= ~val;
      en <= en | 16'h0001;
      core_oe <= 16'($random(seed));
      repeat (4) @(negedge pclk);
      `CHK("cfg held", exp, strap_cfg)
      `CHK("oe follows core", core_oe, gp_oe)
      apb(1'b1, 12'h008, 32'h7, 4'hF);
      apb(1'b1, 12'h008, 32'h0, 4'h0);
      repeat (4) @(negedge pclk);
      `CHK("sideband oe", 3'h6, gp_oe[2:0])
      `CHK("sideband out", 2'h3, gp_out[2:1])
      `CHK("device wake", val[0], device_wake_in)
      `CHK("core in sideband", val[0], core_in[0])
      apb(1'b0, 12'h008, 32'h0, 4'hF);
      `CHK("sideband reg", {val[0], 5'h0, 3'h7}, rd[8:0])
    end
    test_done();
  end
endmodule : wlan_strap_sampler_tb
